/* rtl/flash_pkg.sv */
package flash_pkg;
// Contract
// - Two chip selects; 20, 33 or 50 MHz; with the 40 MHz clock all three settings give a 20 MHz serial clock.
// - Reset rate is 20 MHz until changed.
// - Serial clock rests low between transfers.
// - Each select asserts only for its component.
// - Four data lines: single, dual, quad reads.
// - Bad signature: host only, no regions.
// - Four regions on 4K blocks across components.
// - Bad signature: straps use built-in defaults.
// - Per-region, per-master read and write permission.
// - Override strap drops regions and range four.
// - A master may grant its region away.
// - Lockable protected range per master, read/write.
// - Range four from strap, binds every master.
// - Program access raises SMI when enabled.
// - Refuse chip erase; lockable opcode menu.
// - Hardware builds read/write/erase; software any legal.
// - Separate 64-byte read cache per master.
// - Second component only in descriptor mode.
// - 24-bit address per component, 32MB total.
// - Reset-warn handshake after bus goes idle.

// ==========================================================
// Timing
localparam int unsigned CLOCK_HZ = 40_000_000;
localparam int unsigned RATE20_HZ = 20_000_000;
localparam int unsigned RATE33_HZ = 33_000_000;
localparam int unsigned RATE50_HZ = 50_000_000;
localparam logic [3:0] HALF20 = 4'((CLOCK_HZ + 2 * RATE20_HZ - 1) / (2 * RATE20_HZ));
localparam logic [3:0] HALF33 = 4'((CLOCK_HZ + 2 * RATE33_HZ - 1) / (2 * RATE33_HZ));
localparam logic [3:0] HALF50 = 4'((CLOCK_HZ + 2 * RATE50_HZ - 1) / (2 * RATE50_HZ));
localparam logic [3:0] DUMMY_CLOCKS = 4'h8;

// ==========================================================
// Codes
typedef enum logic [1:0] {RATE_20 = 2'b00, RATE_33 = 2'b01, RATE_50 = 2'b10} rate_t;
typedef enum logic [1:0] {LANE_1 = 2'b00, LANE_2 = 2'b01, LANE_4 = 2'b10} lane_t;
typedef enum logic [2:0] {
	KIND_DIRECT = 3'b000,
	KIND_HW_READ = 3'b001,
	KIND_HW_WRITE = 3'b010,
	KIND_HW_ERASE = 3'b011,
	KIND_SW = 3'b100
} kind_t;
typedef enum logic [2:0] {
	ST_IDLE = 3'b000,
	ST_CHECK = 3'b001,
	ST_FRAME = 3'b010,
	ST_DRAIN = 3'b011,
	ST_GAP = 3'b100,
	ST_SERVE = 3'b101,
	ST_DONE = 3'b110
} state_t;
localparam logic [7:0] OP_READ = 8'h03;
localparam logic [7:0] OP_READ_DUAL = 8'h3B;
localparam logic [7:0] OP_READ_QUAD = 8'h6B;
localparam logic [7:0] OP_WREN = 8'h06;
localparam logic [7:0] OP_PROGRAM = 8'h02;
localparam logic [7:0] OP_ERASE_4K = 8'h20;
localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;

// ==========================================================
// Layout
localparam logic [5:0] CMD_BITS = 6'h20;
localparam logic [9:0] LINE_SAMPLES = 10'h200;
localparam logic [9:0] BYTE_SAMPLES = 10'h008;
localparam logic [3:0] BYTE_BITS = 4'h8;
localparam logic MASTER_HOST = 1'b0;
localparam logic [1:0] REGION_BIOS = 2'h1;
localparam logic [1:0] REGION_ENGINE = 2'h2;
localparam logic PR4_DEFAULT_WP = 1'b0;
localparam logic [12:0] PR4_DEFAULT_BASE = 13'h0000;
localparam logic [12:0] PR4_DEFAULT_LIMIT = 13'h0000;
localparam int unsigned FIFO_WIDTH = 8;
localparam int unsigned FIFO_DEPTH = 4;
endpackage : flash_pkg

/* rtl/boot_flash_spi_controller.sv */
`timescale 1ns/1ps
// ==========================================================
// Response buffer
module rsp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			count_q <= count_d;
			in_ready <= count_d != (AW + 1)'(DEPTH);
			out_valid <= count_d != '0;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule : rsp_fifo

// ==========================================================
// Flash sequencer
module boot_flash_spi_controller (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [1:0] rate_select,
	input wire logic [1:0] read_lanes,
	input wire logic descriptor_valid,
	input wire logic security_override,
	input wire logic [3:0][12:0] region_base,
	input wire logic [3:0][12:0] region_limit,
	input wire logic [1:0][3:0] region_read_perm,
	input wire logic [1:0][3:0] region_write_perm,
	input wire logic [1:0] grant_read,
	input wire logic [1:0] grant_write,
	input wire logic [1:0][12:0] pr_base,
	input wire logic [1:0][12:0] pr_limit,
	input wire logic [1:0] pr_read_protect,
	input wire logic [1:0] pr_write_protect,
	input wire logic [1:0] pr_lock,
	input wire logic [12:0] pr4_strap_base,
	input wire logic [12:0] pr4_strap_limit,
	input wire logic pr4_strap_wp,
	input wire logic smi_write_protect_en,
	input wire logic opcode_lock,
	input wire logic [3:0][7:0] opcode_menu,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_master,
	input wire logic [2:0] req_kind,
	input wire logic req_write,
	input wire logic [24:0] req_addr,
	input wire logic [7:0] req_opcode,
	input wire logic [7:0] req_wdata,
	output logic [7:0] rsp_data,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic done,
	output logic access_error,
	input wire logic access_error_clear,
	output logic smi_request,
	input wire logic reset_warn_req,
	output logic reset_warn_ack,
	output logic flash_serial_clock,
	output logic flash_select_first_n,
	output logic flash_select_second_n,
	output logic [3:0] flash_data_io_out,
	output logic [3:0] flash_data_io_oe_n,
	input wire logic [3:0] flash_data_io_in
);
	function automatic logic in_range(input logic [12:0] b, input logic [12:0] lo,
			input logic [12:0] hi);
		in_range = (b >= lo) && (b <= hi);
	endfunction : in_range

	function automatic logic [3:0] lane_bits(input flash_pkg::lane_t l);
		lane_bits = (l == flash_pkg::LANE_4) ? 4'h4 : (l == flash_pkg::LANE_2) ? 4'h2 : 4'h1;
	endfunction : lane_bits

	flash_pkg::state_t state_q;
	flash_pkg::kind_t kind_q;
	flash_pkg::lane_t lanes_q;
	flash_pkg::lane_t fl_q;
	flash_pkg::rate_t rate_q;
	logic master_q, write_q, wren_q, sclk_q, sel_q, comp_q, ovr_s1_q, ovr_q;
	logic [24:0] eaddr_q;
	logic [7:0] op_q, wdata_q, rx_q, rx_byte_q;
	logic [31:0] sh_q;
	logic [5:0] cmd_q, rx_idx_q;
	logic [3:0] div_q, dummy_q, out_q, rx_bits_q;
	logic [7:0] wd_q;
	logic [9:0] in_q;
	logic [2:0] samp_q;
	logic [3:0] io_s1_q, io_s2_q;
	logic [7:0] cache_q [2][64];
	logic [1:0][18:0] tag_q;
	logic [1:0] tag_ok_q, lock_q;
	logic [1:0][12:0] prb_q, prl_q;
	logic [1:0] prr_q, prw_q;
	logic menu_lock_q;
	logic [3:0][7:0] menu_q;
	logic take, is_read, hit_c, denied_c, wren_c, load_c, rise_in_c, in_phase_c;
	logic [3:0] half_c, lb;
	logic [10:0] left_c;
	logic [7:0] ld_op, rx_d, fifo_data;
	logic [23:0] ld_addr;
	logic [3:0] ld_dummy, ld_out;
	logic [9:0] ld_in;
	flash_pkg::lane_t ld_lanes;
	logic [3:0] io_c, oe_c;
	logic fifo_ready;

	assign take = req_valid && req_ready;
	assign is_read = kind_q == flash_pkg::KIND_DIRECT || kind_q == flash_pkg::KIND_HW_READ
			|| (kind_q == flash_pkg::KIND_SW && !write_q);
	assign hit_c = tag_ok_q[master_q] && tag_q[master_q] == eaddr_q[24:6];
	assign wren_c = state_q == flash_pkg::ST_CHECK
			&& (kind_q == flash_pkg::KIND_HW_WRITE || kind_q == flash_pkg::KIND_HW_ERASE);
	assign load_c = (state_q == flash_pkg::ST_CHECK && !denied_c
			&& !(kind_q == flash_pkg::KIND_DIRECT && hit_c))
			|| (state_q == flash_pkg::ST_GAP && wren_q);
	assign half_c = (rate_q == flash_pkg::RATE_50) ? flash_pkg::HALF50
			: (rate_q == flash_pkg::RATE_33) ? flash_pkg::HALF33 : flash_pkg::HALF20;
	assign left_c = 11'(cmd_q) + 11'(dummy_q) + 11'(out_q) + 11'(in_q);
	assign in_phase_c = cmd_q == '0 && dummy_q == '0 && out_q == '0 && in_q != '0;
	assign rise_in_c = state_q == flash_pkg::ST_FRAME && div_q == '0 && !sclk_q && in_phase_c;
	assign lb = lane_bits(fl_q);

	// ==========================================================
	// Access check
	always_comb begin
		logic [12:0] blk;
		logic [3:0] hit, perm;
		logic other, rgn_ok, pr_blk, pr4_blk, pr4_wp, illegal, wr;
		logic [12:0] pr4_b, pr4_l;
		blk = eaddr_q[24:12];
		wr = write_q || kind_q == flash_pkg::KIND_HW_WRITE || kind_q == flash_pkg::KIND_HW_ERASE;
		other = !master_q;
		for (int r = 0; r < 4; r++) begin
			hit[r] = in_range(blk, region_base[r], region_limit[r]);
		end
		perm = wr ? region_write_perm[master_q] : region_read_perm[master_q];
		if (wr ? grant_write[other] : grant_read[other]) begin
			perm[other == flash_pkg::MASTER_HOST ? flash_pkg::REGION_BIOS
					: flash_pkg::REGION_ENGINE] = 1'b1;
		end
		if (!descriptor_valid) begin
			rgn_ok = master_q == flash_pkg::MASTER_HOST;
		end else begin
			rgn_ok = ovr_q || (|(hit & perm));
		end
		pr_blk = kind_q != flash_pkg::KIND_DIRECT && in_range(blk, prb_q[master_q], prl_q[master_q])
				&& (wr ? prw_q[master_q] : prr_q[master_q]);
		pr4_b = descriptor_valid ? pr4_strap_base : flash_pkg::PR4_DEFAULT_BASE;
		pr4_l = descriptor_valid ? pr4_strap_limit : flash_pkg::PR4_DEFAULT_LIMIT;
		pr4_wp = descriptor_valid ? pr4_strap_wp : flash_pkg::PR4_DEFAULT_WP;
		pr4_blk = wr && kind_q != flash_pkg::KIND_DIRECT && !ovr_q && pr4_wp
				&& in_range(blk, pr4_b, pr4_l);
		illegal = kind_q == flash_pkg::KIND_SW && (op_q == flash_pkg::OP_CHIP_ERASE_A
				|| op_q == flash_pkg::OP_CHIP_ERASE_B
				|| (menu_lock_q && !(op_q == menu_q[0] || op_q == menu_q[1]
				|| op_q == menu_q[2] || op_q == menu_q[3])));
		denied_c = !rgn_ok || pr_blk || pr4_blk || illegal;
	end

	// ==========================================================
	// Frame contents
	always_comb begin
		logic [1:0] sft;
		sft = (lanes_q == flash_pkg::LANE_4) ? 2'h2 : (lanes_q == flash_pkg::LANE_2) ? 2'h1 : 2'h0;
		ld_op = flash_pkg::OP_READ;
		ld_addr = eaddr_q[23:0];
		ld_dummy = 4'h0;
		ld_out = 4'h0;
		ld_in = 10'h000;
		ld_lanes = flash_pkg::LANE_1;
		case (kind_q)
			flash_pkg::KIND_DIRECT, flash_pkg::KIND_HW_READ: begin
				ld_lanes = lanes_q;
				ld_op = (lanes_q == flash_pkg::LANE_4) ? flash_pkg::OP_READ_QUAD
						: (lanes_q == flash_pkg::LANE_2) ? flash_pkg::OP_READ_DUAL : flash_pkg::OP_READ;
				ld_dummy = (lanes_q == flash_pkg::LANE_1) ? 4'h0 : flash_pkg::DUMMY_CLOCKS;
				if (kind_q == flash_pkg::KIND_DIRECT) begin
					ld_addr = {eaddr_q[23:6], 6'h00};
					ld_in = flash_pkg::LINE_SAMPLES >> sft;
				end else begin
					ld_in = flash_pkg::BYTE_SAMPLES >> sft;
				end
			end
			flash_pkg::KIND_HW_WRITE: begin
				ld_op = flash_pkg::OP_PROGRAM;
				ld_out = flash_pkg::BYTE_BITS;
			end
			flash_pkg::KIND_HW_ERASE: begin
				ld_op = flash_pkg::OP_ERASE_4K;
				ld_addr = {eaddr_q[23:12], 12'h000};
			end
			default: begin
				ld_op = op_q;
				ld_out = write_q ? flash_pkg::BYTE_BITS : 4'h0;
				ld_in = write_q ? 10'h000 : flash_pkg::BYTE_SAMPLES;
			end
		endcase
		if (wren_c) begin
			ld_op = flash_pkg::OP_WREN;
			ld_dummy = 4'h0;
			ld_out = 4'h0;
			ld_in = 10'h000;
			ld_lanes = flash_pkg::LANE_1;
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= flash_pkg::ST_IDLE;
			kind_q <= flash_pkg::KIND_DIRECT;
			lanes_q <= flash_pkg::LANE_1;
			fl_q <= flash_pkg::LANE_1;
			rate_q <= flash_pkg::RATE_20;
			master_q <= 1'b0;
			write_q <= 1'b0;
			wren_q <= 1'b0;
			eaddr_q <= '0;
			op_q <= 8'h00;
			wdata_q <= 8'h00;
			sclk_q <= 1'b0;
			sel_q <= 1'b0;
			comp_q <= 1'b0;
			sh_q <= '0;
			cmd_q <= '0;
			dummy_q <= '0;
			out_q <= '0;
			in_q <= '0;
			wd_q <= 8'h00;
			div_q <= '0;
		end else begin
			if (load_c) begin
				sh_q <= {ld_op, ld_addr};
				cmd_q <= wren_c ? 6'h08 : flash_pkg::CMD_BITS;
				dummy_q <= ld_dummy;
				out_q <= ld_out;
				in_q <= ld_in;
				wd_q <= wdata_q;
				fl_q <= ld_lanes;
				div_q <= half_c - 4'h1;
				sel_q <= 1'b1;
				wren_q <= wren_c;
				state_q <= flash_pkg::ST_FRAME;
			end
			case (state_q)
				flash_pkg::ST_IDLE: begin
					if (rate_select != 2'b11) begin
						rate_q <= flash_pkg::rate_t'(rate_select);
					end
					if (take) begin
						master_q <= req_master;
						kind_q <= flash_pkg::kind_t'(req_kind);
						write_q <= req_write;
						eaddr_q <= descriptor_valid ? req_addr : {1'b0, req_addr[23:0]};
						comp_q <= descriptor_valid && req_addr[24];
						op_q <= req_opcode;
						wdata_q <= req_wdata;
						lanes_q <= (read_lanes == 2'b11) ? flash_pkg::LANE_1
								: flash_pkg::lane_t'(read_lanes);
						state_q <= flash_pkg::ST_CHECK;
					end
				end
				flash_pkg::ST_CHECK: begin
					if (denied_c) begin
						state_q <= flash_pkg::ST_DONE;
					end else if (kind_q == flash_pkg::KIND_DIRECT && hit_c) begin
						state_q <= flash_pkg::ST_SERVE;
					end
				end
				flash_pkg::ST_FRAME: begin
					if (div_q != '0) begin
						div_q <= div_q - 4'h1;
					end else begin
						div_q <= half_c - 4'h1;
						sclk_q <= !sclk_q;
						if (sclk_q) begin
							if (cmd_q != '0) begin
								cmd_q <= cmd_q - 6'h01;
								sh_q <= {sh_q[30:0], 1'b0};
							end else if (dummy_q != '0) begin
								dummy_q <= dummy_q - 4'h1;
							end else if (out_q != '0) begin
								out_q <= out_q - 4'h1;
								wd_q <= {wd_q[6:0], 1'b0};
							end else begin
								in_q <= in_q - 10'h001;
							end
							if (left_c == 11'h001) begin
								state_q <= flash_pkg::ST_DRAIN;
							end
						end
					end
				end
				flash_pkg::ST_DRAIN: begin
					if (samp_q == '0) begin
						sel_q <= 1'b0;
						state_q <= flash_pkg::ST_GAP;
					end
				end
				flash_pkg::ST_GAP: begin
					if (!wren_q) begin
						state_q <= is_read ? flash_pkg::ST_SERVE : flash_pkg::ST_DONE;
					end
				end
				flash_pkg::ST_SERVE: begin
					if (fifo_ready) begin
						state_q <= flash_pkg::ST_DONE;
					end
				end
				default: begin
					state_q <= flash_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Receive path
	always_comb begin
		case (fl_q)
			flash_pkg::LANE_4: rx_d = {rx_q[3:0], io_s2_q};
			flash_pkg::LANE_2: rx_d = {rx_q[5:0], io_s2_q[1:0]};
			default: rx_d = {rx_q[6:0], io_s2_q[1]};
		endcase
	end

	// The pins pass two stages, so samples are taken three cycles after the rising edge.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			io_s1_q <= 4'h0;
			io_s2_q <= 4'h0;
			samp_q <= '0;
			rx_q <= 8'h00;
			rx_bits_q <= '0;
			rx_idx_q <= '0;
			rx_byte_q <= 8'h00;
		end else begin
			io_s1_q <= flash_data_io_in;
			io_s2_q <= io_s1_q;
			samp_q <= {samp_q[1:0], rise_in_c};
			if (load_c) begin
				rx_bits_q <= '0;
				rx_idx_q <= '0;
			end else if (samp_q[2]) begin
				rx_q <= rx_d;
				if (rx_bits_q + lb == flash_pkg::BYTE_BITS) begin
					rx_bits_q <= '0;
					rx_idx_q <= rx_idx_q + 6'h01;
					rx_byte_q <= rx_d;
				end else begin
					rx_bits_q <= rx_bits_q + lb;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (samp_q[2] && rx_bits_q + lb == flash_pkg::BYTE_BITS
				&& kind_q == flash_pkg::KIND_DIRECT) begin
			cache_q[master_q][rx_idx_q] <= rx_d;
		end
	end

	// ==========================================================
	// Cache tags, locks and status
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tag_q <= '0;
			tag_ok_q <= 2'b00;
		end else if (state_q == flash_pkg::ST_CHECK && !denied_c) begin
			if (kind_q == flash_pkg::KIND_DIRECT && !hit_c) begin
				tag_q[master_q] <= eaddr_q[24:6];
				tag_ok_q[master_q] <= 1'b0;
			end else if (kind_q != flash_pkg::KIND_DIRECT && kind_q != flash_pkg::KIND_HW_READ) begin
				tag_ok_q <= 2'b00;
			end
		end else if (state_q == flash_pkg::ST_GAP && !wren_q && kind_q == flash_pkg::KIND_DIRECT) begin
			tag_ok_q[master_q] <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lock_q <= 2'b00;
			prb_q <= '0;
			prl_q <= '0;
			prr_q <= 2'b00;
			prw_q <= 2'b00;
			menu_lock_q <= 1'b0;
			menu_q <= '0;
		end else begin
			for (int m = 0; m < 2; m++) begin
				if (!lock_q[m]) begin
					prb_q[m] <= pr_base[m];
					prl_q[m] <= pr_limit[m];
					prr_q[m] <= pr_read_protect[m];
					prw_q[m] <= pr_write_protect[m];
					lock_q[m] <= pr_lock[m];
				end
			end
			if (!menu_lock_q) begin
				menu_q <= opcode_menu;
				menu_lock_q <= opcode_lock;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ovr_s1_q <= 1'b0;
			ovr_q <= 1'b0;
			req_ready <= 1'b0;
			reset_warn_ack <= 1'b0;
			done <= 1'b0;
			access_error <= 1'b0;
			smi_request <= 1'b0;
		end else begin
			ovr_s1_q <= security_override;
			ovr_q <= ovr_s1_q;
			req_ready <= state_q == flash_pkg::ST_IDLE && !take && !reset_warn_req;
			reset_warn_ack <= reset_warn_req && state_q == flash_pkg::ST_IDLE && !take;
			done <= state_q == flash_pkg::ST_DONE;
			access_error <= (access_error && !access_error_clear)
					|| (state_q == flash_pkg::ST_CHECK && denied_c);
			smi_request <= state_q == flash_pkg::ST_CHECK && kind_q != flash_pkg::KIND_DIRECT
					&& smi_write_protect_en;
		end
	end

	// ==========================================================
	// Pin stage
	always_comb begin
		io_c = 4'b1100;
		io_c[0] = (cmd_q != '0) ? sh_q[31] : wd_q[7];
		oe_c = 4'b0010;
		if (state_q == flash_pkg::ST_FRAME && cmd_q == '0 && out_q == '0) begin
			if (fl_q == flash_pkg::LANE_4) begin
				oe_c = 4'b1111;
			end else if (fl_q == flash_pkg::LANE_2) begin
				oe_c = 4'b0011;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flash_serial_clock <= 1'b0;
			flash_select_first_n <= 1'b1;
			flash_select_second_n <= 1'b1;
			flash_data_io_out <= 4'b1100;
			flash_data_io_oe_n <= 4'b0010;
		end else begin
			flash_serial_clock <= sclk_q && state_q == flash_pkg::ST_FRAME;
			flash_select_first_n <= !(sel_q && !comp_q);
			flash_select_second_n <= !(sel_q && comp_q);
			flash_data_io_out <= io_c;
			flash_data_io_oe_n <= oe_c;
		end
	end

	assign fifo_data = (kind_q == flash_pkg::KIND_DIRECT) ? cache_q[master_q][eaddr_q[5:0]]
			: rx_byte_q;

	rsp_fifo #(
		.WIDTH(flash_pkg::FIFO_WIDTH),
		.DEPTH(flash_pkg::FIFO_DEPTH)
	) u_rsp_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(state_q == flash_pkg::ST_SERVE),
		.in_ready(fifo_ready),
		.in_data(fifo_data),
		.out_valid(rsp_valid),
		.out_ready(rsp_ready),
		.out_data(rsp_data)
	);
endmodule : boot_flash_spi_controller

/* bench/flash_model.sv */
`timescale 1ns/1ps
// ==========
// Serial flash part
module flash_model #(
	parameter logic [7:0] FILL = 8'hA5
) (
	input wire logic sclk,
	input wire logic select_n,
	output logic [3:0] dq
);
	int edges_q;
	initial begin
		edges_q = 0;
		dq = 4'h0;
	end
	// Data leaves on falling edges once opcode and address are in.
	// A released part floats, shown as the inverse of the last value.
	always @(negedge sclk or posedge select_n) begin
		if (select_n) begin
			edges_q <= 0;
			dq <= ~dq;
		end else begin
			edges_q <= edges_q + 1;
			if (edges_q >= 31) begin
				dq <= {4{FILL[3'(7 - (edges_q - 31) % 8)]}};
			end
		end
	end
endmodule : flash_model

/* bench/flash_ctrl_asserts.sv */
`timescale 1ns/1ps
// ==========
// Port checks
module flash_ctrl_asserts (
	input wire logic clock,
	input wire logic resetn,
	input wire logic descriptor_valid,
	input wire logic smi_write_protect_en,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [2:0] req_kind,
	input wire logic smi_request,
	input wire logic access_error,
	input wire logic access_error_clear,
	input wire logic reset_warn_req,
	input wire logic reset_warn_ack,
	input wire logic flash_serial_clock,
	input wire logic flash_select_first_n,
	input wire logic flash_select_second_n,
	input wire logic [3:0] flash_data_io_oe_n
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	wire logic quiet = flash_select_first_n && flash_select_second_n;
	a_sclk_rest: assert property (quiet |-> !flash_serial_clock)
		else $error("serial clock high while idle");
	a_one_select: assert property (flash_select_first_n || flash_select_second_n)
		else $error("both selects low");
	a_second_desc: assert property (!flash_select_second_n |-> descriptor_valid)
		else $error("second select outside descriptor mode");
	a_sclk_half: assert property ($rose(flash_serial_clock) |=> $fell(flash_serial_clock))
		else $error("serial clock high too long");
	a_io1_input: assert property (flash_data_io_oe_n[1])
		else $error("io1 driven");
	a_smi_take: assert property (req_valid && req_ready && req_kind != 3'h0
		&& smi_write_protect_en |-> ##[1:3] smi_request) else $error("no smi pulse");
	a_smi_enable: assert property (smi_request |-> smi_write_protect_en)
		else $error("smi while disabled");
	a_err_sticky: assert property (access_error && !access_error_clear |=> access_error)
		else $error("error flag lost");
	a_deny_quiet: assert property ($rose(access_error) |-> quiet)
		else $error("denied access reached flash");
	a_warn_quiet: assert property (reset_warn_ack |-> quiet && !flash_serial_clock)
		else $error("reset warn acked with bus busy");
	a_warn_drop: assert property ($fell(reset_warn_req) |=> !reset_warn_ack)
		else $error("reset warn ack held");
endmodule : flash_ctrl_asserts

bind boot_flash_spi_controller flash_ctrl_asserts chk (.*);

/* bench/boot_flash_spi_controller_tb.sv */
`timescale 1ns/1ps
// ==========
// Bench
module boot_flash_spi_controller_tb;
	logic clock, resetn, descriptor_valid, security_override, pr4_strap_wp, opcode_lock;
	logic smi_write_protect_en, req_valid, req_ready, req_master, req_write, rsp_valid;
	logic rsp_ready, done, access_error, access_error_clear, smi_request, reset_warn_req;
	logic reset_warn_ack, flash_serial_clock, flash_select_first_n, flash_select_second_n;
	logic [1:0] rate_select, read_lanes, grant_read, grant_write, pr_lock;
	logic [1:0] pr_read_protect, pr_write_protect;
	logic [3:0][12:0] region_base, region_limit;
	logic [1:0][3:0] region_read_perm, region_write_perm;
	logic [1:0][12:0] pr_base, pr_limit;
	logic [12:0] pr4_strap_base, pr4_strap_limit;
	logic [3:0][7:0] opcode_menu;
	logic [2:0] req_kind;
	logic [24:0] req_addr;
	logic [7:0] req_opcode, req_wdata, rsp_data, got;
	logic [3:0] flash_data_io_out, flash_data_io_oe_n, flash_data_io_in, dq0, dq1;
	logic s0, s1;
	int fails, n_compared, nsmi, i;

	boot_flash_spi_controller uut (.*);
	flash_model #(.FILL(8'hA5)) m0 (.sclk(flash_serial_clock), .select_n(flash_select_first_n),
		.dq(dq0));
	flash_model #(.FILL(8'h3C)) m1 (.sclk(flash_serial_clock), .select_n(flash_select_second_n),
		.dq(dq1));
	assign flash_data_io_in = (flash_data_io_out & ~flash_data_io_oe_n)
		| ((flash_select_first_n ? dq1 : dq0) & flash_data_io_oe_n);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (rsp_valid === 1'b1) got <= rsp_data;
		if (smi_request === 1'b1) nsmi <= nsmi + 1;
		if (flash_select_first_n === 1'b0) s0 <= 1'b1;
		if (flash_select_second_n === 1'b0) s1 <= 1'b1;
	end

	function automatic logic [7:0] expect_byte(input logic [24:0] a);
		return (a[24] && descriptor_valid) ? 8'h3C : 8'hA5;
	endfunction : expect_byte

	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		n_compared++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk

	// An e of 2 marks a cache hit: no error and no select are expected.
	task automatic xfer(input logic m, input logic [2:0] k, input logic w, input logic [24:0] a,
		input logic [7:0] op, input logic [1:0] e);
		int n;
		logic [1:0] sel;
		n = 0;
		sel = (a[24] && descriptor_valid) ? 2'b10 : 2'b01;
		while (req_ready !== 1'b1 && n < 99) begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
		{req_master, req_kind, req_write, req_addr, req_opcode} <= {m, k, w, a, op};
		req_wdata <= 8'($urandom);
		req_valid <= 1'b1;
		got = 8'h00;
		{s0, s1} = 2'b00;
		@(posedge clock);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (done !== 1'b1 && n < 3000);
		chk({7'h00, done}, 8'h01);
		repeat (4) @(posedge clock);
		#1;
		chk({7'h00, access_error}, {7'h00, e[0]});
		chk({6'h00, s1, s0}, (e != 2'b00) ? 8'h00 : {6'h00, sel});
		if (!e[0] && (k < 3'h2 || (k == 3'h4 && !w)) && read_lanes == 2'h0)
			chk(got, expect_byte(a));
		@(posedge clock);
		access_error_clear <= 1'b1;
		@(posedge clock);
		access_error_clear <= 1'b0;
	endtask : xfer

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	initial begin
		#1_500_000;
		fails++;
		wrap_up;
	end

	initial begin
		{resetn, descriptor_valid, security_override, smi_write_protect_en} = 4'b0100;
		{opcode_lock, req_valid, access_error_clear, reset_warn_req} = '0;
		{rsp_ready, rate_select, read_lanes, grant_read, grant_write, pr_lock} = 11'h400;
		region_base = {13'h0200, 13'h0100, 13'h0001, 13'h0000};
		region_limit = {13'h1FFF, 13'h01FF, 13'h00FF, 13'h0000};
		{region_read_perm, region_write_perm} = {8'h4A, 8'h4A};
		{pr_base, pr_limit} = {13'h1FFF, 13'h00F0, 13'h0000, 13'h00FF};
		{pr_read_protect, pr_write_protect} = 4'b0001;
		{pr4_strap_base, pr4_strap_limit, pr4_strap_wp} = {13'h00E0, 13'h00EF, 1'b1};
		opcode_menu = {8'h20, 8'h02, 8'h06, 8'h03};
		{req_master, req_kind, req_write, req_addr, req_opcode, req_wdata} = '0;
		{fails, n_compared, nsmi} = '0;
		void'($urandom(32'h7B41));
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
		xfer(0, 1, 0, 25'h00FFFFF, 0, 0);
		xfer(0, 1, 0, 25'h1001000, 0, 0);
		xfer(0, 1, 0, 25'h0100000, 0, 1);
		xfer(0, 1, 0, 25'h0000100, 0, 1);
		xfer(1, 1, 0, 25'h0100000, 0, 0);
		grant_read <= 2'b10;
		xfer(0, 1, 0, 25'h0100000, 0, 0);
		grant_read <= 2'b00;
		pr_lock <= 2'b01;
		xfer(0, 2, 0, 25'h00F0000, 0, 1);
		pr_write_protect <= 2'b00;
		xfer(0, 2, 0, 25'h00F0000, 0, 1);
		xfer(0, 2, 0, 25'h00E0000, 0, 1);
		xfer(0, 3, 0, 25'h0002000, 0, 0);
		xfer(0, 4, 1, 25'h0001000, 8'hC7, 1);
		xfer(0, 4, 1, 25'h0001000, 8'h60, 1);
		xfer(0, 4, 0, 25'h0001000, 8'h03, 0);
		opcode_lock <= 1'b1;
		xfer(0, 4, 0, 25'h0001000, 8'h0B, 1);
		$display("test protection finished");
		smi_write_protect_en <= 1'b1;
		nsmi = 0;
		xfer(0, 1, 0, 25'h0003000, 0, 0);
		xfer(0, 3, 0, 25'h00F0000, 0, 1);
		xfer(0, 0, 0, 25'h0003004, 0, 0);
		chk(8'(nsmi), 8'h02);
		smi_write_protect_en <= 1'b0;
		xfer(0, 0, 0, 25'h0003005, 0, 2);
		xfer(1, 0, 0, 25'h0100040, 0, 0);
		descriptor_valid <= 1'b0;
		@(posedge clock);
		xfer(0, 1, 0, 25'h1001000, 0, 0);
		xfer(0, 1, 0, 25'h0100000, 0, 0);
		xfer(1, 1, 0, 25'h0001000, 0, 1);
		xfer(0, 2, 0, 25'h00E0000, 0, 0);
		descriptor_valid <= 1'b1;
		security_override <= 1'b1;
		repeat (3) @(posedge clock);
		xfer(0, 1, 0, 25'h0100000, 0, 0);
		xfer(0, 2, 0, 25'h00E0000, 0, 0);
		security_override <= 1'b0;
		$display("test modes finished");
		for (i = 0; i < 10; i++) begin
			rate_select <= 2'($urandom_range(0, 2));
			read_lanes <= 2'($urandom_range(0, 2));
			xfer(0, 3'($urandom_range(0, 1)), 0, 25'(32'h1000 + $urandom_range(0, 32'hFEFFF)),
				0, 0);
		end
		{rate_select, read_lanes} <= 4'h0;
		$display("test random finished");
		reset_warn_req <= 1'b1;
		i = 0;
		while (reset_warn_ack !== 1'b1 && i < 99) begin
			@(posedge clock);
			#1;
			i++;
		end
		chk({7'h00, reset_warn_ack, req_ready}, 8'h02);
		@(posedge clock);
		reset_warn_req <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk({7'h00, reset_warn_ack}, 8'h00);
		@(posedge clock);
		rsp_ready <= 1'b0;
		for (i = 0; i < 4; i++) xfer(0, 1, 0, 25'(32'h1000 + 64 * i), 0, 0);
		#1;
		chk({7'h00, rsp_valid}, 8'h01);
		@(posedge clock);
		rsp_ready <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			#1;
			i++;
		end while (rsp_valid === 1'b1 && i < 9);
		chk(8'(i), 8'(flash_pkg::FIFO_DEPTH));
		$display("test buffer finished");
		wrap_up;
	end
endmodule : boot_flash_spi_controller_tb
